/* File: rtl/dtc_cfg.svh */
// Purpose: constants for the dual 8-bit timer/counter block
// Assumes: register indices; byte address is four times the index
// Notes: definitions only
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH
`define DTC_IDX_LO_CTRL 8'h20
`define DTC_IDX_HI_CTRL 8'h21
`define DTC_IDX_LO_PER 8'h22
`define DTC_IDX_LO_DUTY 8'h23
`define DTC_IDX_HI_PER 8'h24
`define DTC_IDX_HI_DUTY 8'h25
`define DTC_IDX_OPT 8'h26
`define DTC_IDX_COUNT 8'h27
`define DTC_CTRL_RST 8'h00
`define DTC_CMP_RST 8'h00
`define DTC_FF_BIT 7
`define DTC_CK_HI 6
`define DTC_CK_LO 4
`define DTC_RUN_BIT 3
`define DTC_MD_HI 2
`define DTC_MD_LO 0
`define DTC_MODE_T8 3'h0
`define DTC_MODE_DIV 3'h1
`define DTC_MODE_PWM8 3'h2
`define DTC_MODE_CASC 3'h3
`define DTC_MODE_T16 3'h4
`define DTC_MODE_WARM 3'h5
`define DTC_MODE_PWM16 3'h6
`define DTC_MODE_PPG 3'h7
`define DTC_CK_TAP11 3'h0
`define DTC_CK_TAP7 3'h1
`define DTC_CK_TAP5 3'h2
`define DTC_CK_TAP3 3'h3
`define DTC_CK_PIN 3'h7
`define DTC_DIV_W 13
`endif

/* File: rtl/dtc_pkg.sv */
// Purpose: types for the dual 8-bit timer/counter block
// Assumes: constants come from dtc_cfg.svh
// Notes: state records of both modules
package dtc_pkg;
	typedef struct packed {
		logic [7:0] cnt;
	} dtc_unit_st_t;

	typedef struct packed {
		logic [7:0] ctrl_lo;
		logic [7:0] ctrl_hi;
		logic [7:0] per_lo;
		logic [7:0] per_hi;
		logic [7:0] duty_lo;
		logic [7:0] duty_hi;
		logic opt;
		logic [12:0] div;
		logic [2:0] pin_lo;
		logic [2:0] pin_hi;
		logic ack;
		logic [31:0] rdata;
		logic irq_lo;
		logic irq_hi;
	} dtc_top_st_t;
endpackage : dtc_pkg

/* File: rtl/dtc_unit.sv */
// Purpose: one 8-bit up-counter stage
// Assumes: tick and clear come from the same clock domain
// Notes: clear beats tick; stopped means held at zero
`timescale 1ns/1ps
`default_nettype none
module dtc_unit #(
	parameter int W = 8
) (
	input wire logic sys_clk_i, // system clock
	input wire logic rst_i, // sync reset, high
	input wire logic run_i, // counting allowed
	input wire logic tick_i, // count enable pulse
	input wire logic clr_i, // match clear pulse
	output logic [W-1:0] cnt_o // counter value
);
	dtc_pkg::dtc_unit_st_t st;
	dtc_pkg::dtc_unit_st_t next_st;

	always_comb begin
		next_st = st;
		if (!run_i || clr_i) begin
			next_st.cnt = '0;
		end else if (tick_i) begin
			next_st.cnt = st.cnt + 8'h01;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign cnt_o = st.cnt;
endmodule : dtc_unit
`default_nettype wire

/* File: rtl/dtc_top.sv */
// Purpose: dual cascadable 8-bit timer/event counter with registers
// Assumes: Avalon-MM slave, 20 MHz system clock, pins asynchronous
// Notes: only 8-bit and 16-bit timer/event modes count
`include "dtc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
// Function
// - upper control resets zero, fixed field layout
// - clock select picks prescaler tap or pin
// - run bit zero stops and clears counter
// - mode field decodes only the 8-bit and 16-bit timer modes
// - upper 16-bit mode clocks on cascade overflow
// - 16-bit: lower clock, upper run control
// - timer counts, match interrupts, clears, continues
// - period compare takes effect at once
// - event mode counts pin falling edges
// - two counters cascade into sixteen bits
// - lower control, period and duty registers
module dtc_top (
	input wire logic sys_clk_i, // system clock
	input wire logic rst_i, // sync reset, high
	input wire logic [9:0] avs_address_i, // byte address
	input wire logic avs_read_i, // read request
	input wire logic avs_write_i, // write request
	input wire logic [31:0] avs_writedata_i, // write data
	output logic [31:0] avs_readdata_o, // read data
	output logic avs_waitrequest_o, // stall
	input wire logic event_input_pin_lo_i, // lower event pin
	input wire logic event_input_pin_hi_i, // upper event pin
	output logic counter_match_irq_lo_o, // lower match pulse
	output logic counter_match_irq_hi_o, // upper match pulse
	output logic upper_flipflop_preset_o, // upper preset bit
	output logic lower_flipflop_preset_o // lower preset bit
);
	dtc_pkg::dtc_top_st_t st;
	dtc_pkg::dtc_top_st_t next_st;
	logic [7:0] cnt_lo;
	logic [7:0] cnt_hi;
	logic [2:0] mode_lo;
	logic [2:0] mode_hi;
	logic mode16;
	logic act_lo;
	logic act_hi;
	logic fall_lo;
	logic fall_hi;
	logic tick_lo;
	logic tick_hi;
	logic carry;
	logic match_lo;
	logic match_hi;
	logic match16;
	logic clr_lo;
	logic clr_hi;
	logic [15:0] inc16;
	logic [7:0] idx;
	logic req;

	// tap select; halving adds one stage
	function automatic logic sel_tick(input logic [2:0] cs,
		input logic opt, input logic [12:0] div, input logic fall);
		logic [12:0] m;
		m = '0;
		case (cs)
			`DTC_CK_TAP11: m = opt ? 13'h0FFF : 13'h07FF;
			`DTC_CK_TAP7: m = opt ? 13'h00FF : 13'h007F;
			`DTC_CK_TAP5: m = opt ? 13'h003F : 13'h001F;
			`DTC_CK_TAP3: m = opt ? 13'h000F : 13'h0007;
			default: m = '0;
		endcase
		if (cs == `DTC_CK_PIN) begin
			sel_tick = fall;
		end else if (m == '0) begin
			sel_tick = 1'b0;
		end else begin
			sel_tick = ((div & m) == m);
		end
	endfunction : sel_tick

	always_comb begin
		mode_lo = st.ctrl_lo[`DTC_MD_HI:`DTC_MD_LO];
		mode_hi = st.ctrl_hi[`DTC_MD_HI:`DTC_MD_LO];
		// mode decode; top bit marks a 16-bit mode
		mode16 = mode_hi[2];
		// run from upper control in 16-bit operation
		act_lo = mode16 ? (st.ctrl_hi[`DTC_RUN_BIT] &&
			mode_hi == `DTC_MODE_T16) :
			(st.ctrl_lo[`DTC_RUN_BIT] && mode_lo == `DTC_MODE_T8);
		act_hi = st.ctrl_hi[`DTC_RUN_BIT] &&
			(mode_hi == `DTC_MODE_T8 || mode_hi == `DTC_MODE_T16);
		fall_lo = st.pin_lo[2] & ~st.pin_lo[1];
		fall_hi = st.pin_hi[2] & ~st.pin_hi[1];
		// lower clock select feeds the 16-bit chain
		tick_lo = act_lo && sel_tick(
			st.ctrl_lo[`DTC_CK_HI:`DTC_CK_LO], st.opt, st.div, fall_lo);
		carry = tick_lo && (cnt_lo == 8'hFF);
		// upper stage clocked by cascade overflow in 16-bit mode
		tick_hi = mode16 ? (act_hi && carry) : (act_hi && sel_tick(
			st.ctrl_hi[`DTC_CK_HI:`DTC_CK_LO], st.opt, st.div, fall_hi));
		// compare reads the live period register
		match_lo = !mode16 && tick_lo &&
			(8'(cnt_lo + 8'h01) == st.per_lo);
		match_hi = !mode16 && tick_hi &&
			(8'(cnt_hi + 8'h01) == st.per_hi);
		inc16 = 16'({cnt_hi, cnt_lo} + 16'h0001);
		match16 = mode16 && tick_lo && (inc16 == {st.per_hi, st.per_lo});
		clr_lo = match_lo || match16;
		clr_hi = match_hi || match16;
	end

	dtc_unit #(.W(8)) u_lo (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.run_i(act_lo),
		.tick_i(tick_lo),
		.clr_i(clr_lo),
		.cnt_o(cnt_lo)
	);

	dtc_unit #(.W(8)) u_hi (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.run_i(act_hi),
		.tick_i(tick_hi),
		.clr_i(clr_hi),
		.cnt_o(cnt_hi)
	);

	assign idx = avs_address_i[9:2];
	assign req = avs_read_i | avs_write_i;

	always_comb begin
		next_st = st;
		// free-running prescaler; taps are one-cycle enables
		next_st.div = 13'(st.div + 13'h0001);
		// two flops before the edge stage reads the pin
		next_st.pin_lo = {st.pin_lo[1:0], event_input_pin_lo_i};
		next_st.pin_hi = {st.pin_hi[1:0], event_input_pin_hi_i};
		next_st.irq_lo = match_lo;
		next_st.irq_hi = match_hi || match16;
		// one wait cycle per access, answer on the second
		next_st.ack = req && !st.ack;
		if (req && !st.ack && avs_read_i) begin
			case (idx)
				`DTC_IDX_LO_CTRL: next_st.rdata = {24'h0, st.ctrl_lo};
				`DTC_IDX_HI_CTRL: next_st.rdata = {24'h0, st.ctrl_hi};
				`DTC_IDX_LO_PER: next_st.rdata = {24'h0, st.per_lo};
				`DTC_IDX_LO_DUTY: next_st.rdata = {24'h0, st.duty_lo};
				`DTC_IDX_HI_PER: next_st.rdata = {24'h0, st.per_hi};
				`DTC_IDX_HI_DUTY: next_st.rdata = {24'h0, st.duty_hi};
				`DTC_IDX_OPT: next_st.rdata = {31'h0, st.opt};
				`DTC_IDX_COUNT: next_st.rdata = {16'h0, cnt_hi, cnt_lo};
				default: next_st.rdata = 32'h0;
			endcase
		end
		// writes land at the edge where waitrequest is low
		if (avs_write_i && st.ack) begin
			case (idx)
				`DTC_IDX_LO_CTRL: next_st.ctrl_lo = avs_writedata_i[7:0];
				`DTC_IDX_HI_CTRL: next_st.ctrl_hi = avs_writedata_i[7:0];
				// no shadow copy in timer modes
				`DTC_IDX_LO_PER: next_st.per_lo = avs_writedata_i[7:0];
				`DTC_IDX_LO_DUTY: next_st.duty_lo = avs_writedata_i[7:0];
				`DTC_IDX_HI_PER: next_st.per_hi = avs_writedata_i[7:0];
				`DTC_IDX_HI_DUTY: next_st.duty_hi = avs_writedata_i[7:0];
				`DTC_IDX_OPT: next_st.opt = avs_writedata_i[0];
				default: next_st.opt = st.opt;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st <= '0;
			st.ctrl_lo <= `DTC_CTRL_RST;
			st.ctrl_hi <= `DTC_CTRL_RST;
			st.per_lo <= `DTC_CMP_RST;
			st.per_hi <= `DTC_CMP_RST;
		end else begin
			st <= next_st;
		end
	end

	assign avs_waitrequest_o = req && !st.ack;
	assign avs_readdata_o = st.rdata;
	assign counter_match_irq_lo_o = st.irq_lo;
	assign counter_match_irq_hi_o = st.irq_hi;
	// each preset output follows bit 7 of its own control, also in 16-bit mode
	assign upper_flipflop_preset_o = st.ctrl_hi[`DTC_FF_BIT];
	assign lower_flipflop_preset_o = st.ctrl_lo[`DTC_FF_BIT];
endmodule : dtc_top
`default_nettype wire

/* File: verification/dtc_ev_src.sv */
// Purpose: event pulse source for the counter pins
// Assumes: pin idles high, falling edges count
// Notes: every level lasts eight clocks, the slowest legal rate
`timescale 1ns/1ps
`default_nettype none
module dtc_ev_src (
	input wire logic sys_clk_i, // clock
	input wire logic [7:0] n_i, // total falls wanted
	output logic pin_o // event pin
);
	logic [7:0] sent = 8'h00;
	logic [2:0] ph = 3'h0;
	logic lvl = 1'b1;
	assign pin_o = lvl;
	always @(posedge sys_clk_i) begin
		ph <= ph + 3'h1;
		if (ph == 3'h7 && (sent != n_i || !lvl)) begin
			lvl <= !lvl;
			sent <= sent + {7'h0, lvl};
		end
	end
endmodule : dtc_ev_src
`default_nettype wire

/* File: verification/dtc_top_properties.sv */
// Purpose: port checks for dtc_top
// Assumes: one wait cycle per access
// Notes: pins are judged by the bench
`include "dtc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dtc_top_properties (
	input wire logic sys_clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic [9:0] avs_address_i, // address
	input wire logic avs_read_i, // read
	input wire logic avs_write_i, // write
	input wire logic [31:0] avs_writedata_i, // wdata
	input wire logic [31:0] avs_readdata_o, // rdata
	input wire logic avs_waitrequest_o, // stall
	input wire logic counter_match_irq_lo_o, // lo irq
	input wire logic counter_match_irq_hi_o, // hi irq
	input wire logic upper_flipflop_preset_o, // hi preset
	input wire logic lower_flipflop_preset_o // lo preset
);
	default clocking cb @(posedge sys_clk_i); endclocking
	wire logic il = counter_match_irq_lo_o;
	wire logic ih = counter_match_irq_hi_o;
	wire logic wa = avs_write_i && !avs_waitrequest_o;
	wire logic [7:0] ix = avs_address_i[9:2];
	lo_pulse_a: assert property (disable iff (rst_i) il |=> !il)
		else $error("lo irq too long");
	hi_pulse_a: assert property (disable iff (rst_i) ih |=> !ih)
		else $error("hi irq too long");
	rst_irq_a: assert property (rst_i |=> !il && !ih)
		else $error("irq in reset");
	rst_data_a: assert property (rst_i |=> avs_readdata_o == 32'h0)
		else $error("rdata not cleared");
	rst_preset_a: assert property (rst_i |=>
		!upper_flipflop_preset_o && !lower_flipflop_preset_o)
		else $error("preset not cleared");
	one_wait_a: assert property (disable iff (rst_i)
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("access not answered");
	hi_ff_a: assert property (disable iff (rst_i)
		wa && ix == `DTC_IDX_HI_CTRL |=>
		upper_flipflop_preset_o == $past(avs_writedata_i[7]))
		else $error("hi preset not written");
	lo_ff_a: assert property (disable iff (rst_i)
		wa && ix == `DTC_IDX_LO_CTRL |=>
		lower_flipflop_preset_o == $past(avs_writedata_i[7]))
		else $error("lo preset not written");
endmodule : dtc_top_properties
bind dtc_top dtc_top_properties i_dtc_top_properties (
	.sys_clk_i(sys_clk_i),
	.rst_i(rst_i),
	.avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i),
	.avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o),
	.counter_match_irq_lo_o(counter_match_irq_lo_o),
	.counter_match_irq_hi_o(counter_match_irq_hi_o),
	.upper_flipflop_preset_o(upper_flipflop_preset_o),
	.lower_flipflop_preset_o(lower_flipflop_preset_o)
);
`default_nettype wire

/* File: verification/test_dtc_top.sv */
// Purpose: self-checking bench for dtc_top
// Assumes: one pulse source feeds both pins
// Notes: gaps are period times tap length
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("[ERR] %0t got %0h want %0h", $time, a, b); end end
module test_dtc_top;
	logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [31:0] wd = 32'h0, q;
	logic [7:0] ne = 8'h00;
	logic [3:0] cfg [5] = '{4'h3, 4'h2, 4'h1, 4'h0, 4'hB};
	int gaps [5] = '{16, 64, 256, 4096, 32};
	int miscompares = 0, n_checks = 0, ni = 0, n, k;
	wire logic [31:0] rdat;
	wire logic wq, pin, il, ih, fh, fl;
	dtc_top i_dtc_top (.sys_clk_i(clk), .rst_i(rst), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wq),
		.event_input_pin_lo_i(pin), .event_input_pin_hi_i(pin),
		.counter_match_irq_lo_o(il), .counter_match_irq_hi_o(ih),
		.upper_flipflop_preset_o(fh), .lower_flipflop_preset_o(fl));
	dtc_ev_src i_dtc_ev_src (.sys_clk_i(clk), .n_i(ne), .pin_o(pin));
	initial forever #25 clk = !clk;
	always @(posedge clk) ni <= ni + (il === 1'b1) + (ih === 1'b1);
	task automatic bus(input logic w, input logic [7:0] a, d);
		@(posedge clk);
		{adr, wd, rd, wr} <= {a, 2'h0, 24'h0, d, !w, w};
		// held until the edge that sees waitrequest low
		do @(posedge clk); while (wq !== 1'b0);
		q = rdat;
		{rd, wr} <= 2'h0;
	endtask : bus
	task automatic gap(input logic hi);
		repeat (2) begin
			n = 1;
			do @(negedge clk); while ((hi ? ih : il) !== 1'b1 && ++n < 9000);
		end
	endtask : gap
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		tally_and_finish;
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, 8'h21, 8'h00);
		`CHK(q, 32'h0)
		for (int m = 0; m < 8; m++) begin
			bus(1'b1, 8'h21, {5'h0, m[2:0]});
			bus(1'b0, 8'h21, 8'h00);
			`CHK(q, {29'h0, m[2:0]})
		end
		bus(1'b1, 8'h21, 8'hF0);
		bus(1'b1, 8'h20, 8'h80);
		bus(1'b1, 8'h30, 8'hAA);
		bus(1'b0, 8'h30, 8'h00);
		`CHK({q, fh, fl}, {32'h0, 2'h3})
		bus(1'b1, 8'h21, 8'h00);
		bus(1'b1, 8'h20, 8'h00);
		bus(1'b1, 8'h22, 8'h02);
		bus(1'b1, 8'h23, 8'h01);
		bus(1'b0, 8'h23, 8'h00);
		`CHK(q, 32'h1)
		bus(1'b0, 8'h22, 8'h00);
		`CHK(q, 32'h2)
		$display("registers done");
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, 8'h26, {7'h0, cfg[i][3]});
			bus(1'b1, 8'h20, {1'b0, cfg[i][2:0], 4'h8});
			gap(1'b0);
			`CHK(n, gaps[i])
			bus(1'b1, 8'h20, {1'b0, cfg[i][2:0], 4'h0});
			bus(1'b0, 8'h27, 8'h00);
			`CHK(q, 32'h0)
		end
		bus(1'b1, 8'h26, 8'h00);
		bus(1'b1, 8'h24, 8'h01);
		bus(1'b1, 8'h20, 8'h33);
		bus(1'b1, 8'h21, 8'h0C);
		gap(1'b1);
		`CHK(n, 32'h810)
		bus(1'b1, 8'h21, 8'h04);
		$display("timers done");
		bus(1'b1, 8'h22, 8'h05);
		bus(1'b1, 8'h24, 8'h05);
		bus(1'b1, 8'h20, 8'h78);
		bus(1'b1, 8'h21, 8'h78);
		k = ni;
		ne <= 8'h04;
		repeat (80) @(posedge clk);
		bus(1'b0, 8'h27, 8'h00);
		`CHK({q, ni}, {32'h404, k})
		ne <= 8'h05;
		repeat (24) @(posedge clk);
		bus(1'b0, 8'h27, 8'h00);
		`CHK({q, ni}, {32'h0, k + 2})
		$display("events done");
		tally_and_finish;
	end
endmodule : test_dtc_top
`default_nettype wire
